// ==== dv/tb.sv ====
// Self-checking bench for the correction register bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               mclk_i = 1'b0;
  logic               sys_rst_i = 1'b1;
  logic               wr_i = 1'b0;
  logic               rd_i = 1'b0;
  logic [7:0]         addr_i = 8'h00;
  logic [7:0]         wdata_i = 8'h00;
  logic [7:0]         rdata_o;
  iqc_pkg::iqc_sync_t sync_i = '0;
  logic [15:0]        sample_a_i = 16'h0100;
  logic [15:0]        sample_b_i = 16'h0200;
  logic [15:0]        converter_a_o;
  logic [15:0]        converter_b_o;
  logic [10:0]        gain_a_hi_o;
  logic [10:0]        gain_b_hi_o;
  logic [9:0]         phase_hi_o;
  logic               nco_phase_sync_o;
  logic               nco_reg_sync_o;
  int                 fail_count = 0;
  int                 checks = 0;

  always #2.5 mclk_i = ~mclk_i;

  iqc_regs dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .sync_i(sync_i), .sample_a_i(sample_a_i), .sample_b_i(sample_b_i),
    .converter_a_o(converter_a_o), .converter_b_o(converter_b_o), .gain_a_hi_o(gain_a_hi_o),
    .gain_b_hi_o(gain_b_hi_o), .phase_hi_o(phase_hi_o), .nco_phase_sync_o(nco_phase_sync_o),
    .nco_reg_sync_o(nco_reg_sync_o));

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (exp !== got) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    @(negedge mclk_i);
    check($sformatf("rdata at %h", a), {8'h00, exp}, {8'h00, rdata_o});
  endtask

  task automatic pulse(input logic [2:0] s);
    @(posedge mclk_i);
    sync_i <= s;
    @(posedge mclk_i);
    sync_i <= '0;
  endtask

  task automatic settle;
    @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    logic [7:0] a [9];
    logic [7:0] e [9];
    a = '{8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h40};
    e = '{8'h24, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h15, 8'h00};
    foreach (a[i]) rd(a[i], e[i]);
    check("unity gain a", 16'h0400, {5'h00, gain_a_hi_o});
    check("unity gain b", 16'h0400, {5'h00, gain_b_hi_o});
    check("phase zero", 16'h0000, {6'h00, phase_hi_o});
  endtask

  // Negative offset on A, held back until the fifo sync
  task automatic t_offset_a;
    wr(8'h10, 8'hff);
    wr(8'h12, 8'hff);
    rd(8'h12, 8'hf8);
    settle();
    check("conv a before sync", 16'h0100, converter_a_o);
    pulse(3'b010);
    settle();
    check("conv a offset -1", 16'h00ff, converter_a_o);
  endtask

  // Zero selector never loads; control sync bit then does
  task automatic t_offset_b;
    wr(8'h16, 8'h1f);
    wr(8'h11, 8'h05);
    wr(8'h13, 8'h08);
    wr(8'h0f, 8'h7a);
    pulse(3'b111);
    settle();
    check("conv b zero sel", 16'h0200, converter_b_o);
    check("gain a zero sel", 16'h0400, {5'h00, gain_a_hi_o});
    wr(8'h0f, 8'h24);
    wr(8'h16, 8'h16);
    pulse(3'b010);
    settle();
    check("conv b wrong sync", 16'h0200, converter_b_o);
    pulse(3'b001);
    settle();
    check("conv b offset", 16'h0305, converter_b_o);
  endtask

  task automatic t_corr_upper;
    wr(8'h16, 8'h15);
    wr(8'h0f, 8'h7a);
    settle();
    check("gain a before sync", 16'h0400, {5'h00, gain_a_hi_o});
    pulse(3'b010);
    settle();
    check("gain a", 16'h0700, {5'h00, gain_a_hi_o});
    check("gain b", 16'h0200, {5'h00, gain_b_hi_o});
    check("phase", 16'h0100, {6'h00, phase_hi_o});
  endtask

  // Oscillator syncs follow their reset-time sources
  task automatic t_nco_sync;
    pulse(3'b100);
    @(negedge mclk_i);
    check("nco phase sync", 16'h0001, {15'h0000, nco_phase_sync_o});
    check("nco reg quiet", 16'h0000, {15'h0000, nco_reg_sync_o});
    pulse(3'b010);
    @(negedge mclk_i);
    check("nco reg sync", 16'h0001, {15'h0000, nco_reg_sync_o});
    check("nco phase quiet", 16'h0000, {15'h0000, nco_phase_sync_o});
  endtask

  // Samples at the range ends: offsets clip rather than wrap
  task automatic t_sample;
    @(posedge mclk_i);
    sample_a_i <= 16'h0000;
    sample_b_i <= 16'h0000;
    settle();
    check("conv a zero sample", 16'hffff, converter_a_o);
    check("conv b zero sample", 16'h0105, converter_b_o);
    // Write lands in the shadow while the offset sync is held high
    @(posedge mclk_i);
    addr_i     <= 8'h10;
    wdata_i    <= 8'h00;
    wr_i       <= 1'b1;
    sync_i     <= 3'b010;
    sample_b_i <= 16'h7fff;
    @(posedge mclk_i);
    wr_i       <= 1'b0;
    @(posedge mclk_i);
    sync_i     <= '0;
    settle();
    check("conv a write on sync", 16'hff00, converter_a_o);
    check("conv b high clip", 16'h7fff, converter_b_o);
    @(posedge mclk_i);
    sample_a_i <= 16'h8000;
    settle();
    check("conv a low clip", 16'h8000, converter_a_o);
  endtask

  task automatic t_test_value;
    wr(8'h14, 8'h01);
    wr(8'h15, 8'h80);
    wr(8'h1b, 8'h01);
    settle();
    check("test on a", 16'h8001, converter_a_o);
    check("test on b", 16'h8001, converter_b_o);
    rd(8'h1b, 8'h01);
  endtask

  task automatic report_and_stop;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run is about a hundred cycles
  initial begin
    #20000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_reset_values();
    t_offset_a();
    t_offset_b();
    t_corr_upper();
    t_nco_sync();
    t_sample();
    t_test_value();
    report_and_stop();
  end
endmodule

// ==== verilog/iqc_pkg.sv ====
// Package: register map, field layout, sync encodings and carriers
package iqc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CORR_UPPER = 8'h0f;
  localparam logic [7:0] ADDR_OFS_A_LO   = 8'h10;
  localparam logic [7:0] ADDR_OFS_B_LO   = 8'h11;
  localparam logic [7:0] ADDR_OFS_A_HI   = 8'h12;
  localparam logic [7:0] ADDR_OFS_B_HI   = 8'h13;
  localparam logic [7:0] ADDR_TEST_LO    = 8'h14;
  localparam logic [7:0] ADDR_TEST_HI    = 8'h15;
  localparam logic [7:0] ADDR_SYNC_SEL   = 8'h16;
  localparam logic [7:0] ADDR_TEST_CTRL  = 8'h1b;
  // ----------------------------------------------------------------
  // Reset values and write mask
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CORR_UPPER = 8'h24;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_SYNC_SEL   = 8'h15;
  localparam logic [7:0] HI_OFS_MASK    = 8'hf8;
  // ----------------------------------------------------------------
  // Sync source encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SYNC_TXGATE = 2'h0;
  localparam logic [1:0] SYNC_FIFO   = 2'h1;
  localparam logic [1:0] SYNC_CTRL   = 2'h2;
  localparam logic [1:0] SYNC_ZERO   = 2'h3;

  typedef struct packed {
    logic [1:0] nco_phase;
    logic [1:0] nco_reg;
    logic [1:0] corr;
    logic [1:0] offset;
  } iqc_sel_t;

  typedef struct packed {
    logic [1:0]  phase_hi;
    logic [2:0]  gain_a_hi;
    logic [2:0]  gain_b_hi;
  } iqc_upper_t;

  typedef struct packed {
    logic transmit_gate;
    logic fifo_sync;
    logic ctrl_if_sync_bit;
  } iqc_sync_t;
endpackage

// ==== verilog/iqc_regs.sv ====
// Correction register bank with sync-qualified shadows and output datapath
module iqc_regs #(
  parameter int DW = 16,
  parameter int OW = 13
) (
  input  wire logic              mclk_i,        // Data clock
  input  wire logic              sys_rst_i,     // Sync reset, high
  input  wire logic [7:0]        addr_i,        // Register address
  input  wire logic [7:0]        wdata_i,       // Write data
  input  wire logic              wr_i,          // Write strobe
  input  wire logic              rd_i,          // Read strobe
  output logic      [7:0]        rdata_o,       // Read data, next cycle
  input  wire iqc_pkg::iqc_sync_t sync_i,       // Sync events, same clock
  input  wire logic [DW-1:0]     sample_a_i,    // Channel A sample
  input  wire logic [DW-1:0]     sample_b_i,    // Channel B sample
  output logic      [DW-1:0]     converter_a_o, // Channel A output
  output logic      [DW-1:0]     converter_b_o, // Channel B output
  output logic      [10:0]       gain_a_hi_o,   // Gain A, upper bits at 10:8
  output logic      [10:0]       gain_b_hi_o,   // Gain B, upper bits at 10:8
  output logic      [9:0]        phase_hi_o,    // Phase, upper bits at 9:8
  output logic                   nco_phase_sync_o, // Oscillator phase sync
  output logic                   nco_reg_sync_o    // Oscillator register sync
);
  if (DW != 16 || OW != 13) begin : g_width_chk
    $error("iqc_regs: widths fixed at 16/13");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Sync source decode
  function automatic logic pick_sync(input logic [1:0] sel, input iqc_pkg::iqc_sync_t s);
    case (sel)
      iqc_pkg::SYNC_TXGATE: pick_sync = s.transmit_gate;
      iqc_pkg::SYNC_FIFO:   pick_sync = s.fifo_sync;
      iqc_pkg::SYNC_CTRL:   pick_sync = s.ctrl_if_sync_bit;
      default:              pick_sync = 1'b0;
    endcase
  endfunction

  function automatic logic [DW-1:0] sat_add(input logic [DW-1:0] s, input logic [OW-1:0] o);
    logic signed [DW:0] sum;
    sum = $signed({s[DW-1], s}) + $signed({{(DW-OW+1){o[OW-1]}}, o});
    if (sum[DW] != sum[DW-1]) sat_add = {sum[DW], {(DW-1){~sum[DW]}}};
    else sat_add = sum[DW-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] upper_sh, ofs_a_lo_sh, ofs_b_lo_sh, ofs_a_hi_sh, ofs_b_hi_sh;
  logic [7:0] upper_act, ofs_a_lo, ofs_b_lo, ofs_a_hi, ofs_b_hi;
  logic [7:0] test_lo, test_hi, test_ctrl;
  iqc_pkg::iqc_sel_t sel;
  logic [7:0] next_upper_sh, next_ofs_a_lo_sh, next_ofs_b_lo_sh, next_ofs_a_hi_sh, next_ofs_b_hi_sh;
  logic [7:0] next_upper_act, next_ofs_a_lo, next_ofs_b_lo, next_ofs_a_hi, next_ofs_b_hi;
  logic [7:0] next_test_lo, next_test_hi, next_test_ctrl, next_rdata;
  iqc_pkg::iqc_sel_t next_sel;
  logic corr_ld, ofs_ld;

  always_comb begin
    next_upper_sh    = upper_sh;
    next_ofs_a_lo_sh = ofs_a_lo_sh;
    next_ofs_b_lo_sh = ofs_b_lo_sh;
    next_ofs_a_hi_sh = ofs_a_hi_sh;
    next_ofs_b_hi_sh = ofs_b_hi_sh;
    next_test_lo     = test_lo;
    next_test_hi     = test_hi;
    next_test_ctrl   = test_ctrl;
    next_sel         = sel;
    if (wr_i) begin
      case (addr_i)
        iqc_pkg::ADDR_CORR_UPPER: next_upper_sh = wdata_i;
        iqc_pkg::ADDR_OFS_A_LO:   next_ofs_a_lo_sh = wdata_i;
        iqc_pkg::ADDR_OFS_B_LO:   next_ofs_b_lo_sh = wdata_i;
        iqc_pkg::ADDR_OFS_A_HI:   next_ofs_a_hi_sh = wdata_i & iqc_pkg::HI_OFS_MASK;
        iqc_pkg::ADDR_OFS_B_HI:   next_ofs_b_hi_sh = wdata_i & iqc_pkg::HI_OFS_MASK;
        iqc_pkg::ADDR_TEST_LO:    next_test_lo = wdata_i;
        iqc_pkg::ADDR_TEST_HI:    next_test_hi = wdata_i;
        iqc_pkg::ADDR_SYNC_SEL:   next_sel = iqc_pkg::iqc_sel_t'(wdata_i);
        iqc_pkg::ADDR_TEST_CTRL:  next_test_ctrl = {7'h00, wdata_i[0]};
        default: ;
      endcase
    end
  end

  // Shadow to active on selected sync
  always_comb begin
    corr_ld        = pick_sync(sel.corr, sync_i);
    ofs_ld         = pick_sync(sel.offset, sync_i);
    next_upper_act = corr_ld ? upper_sh : upper_act;
    // Offsets load only on offset sync
    next_ofs_a_lo  = ofs_ld ? ofs_a_lo_sh : ofs_a_lo;
    next_ofs_b_lo  = ofs_ld ? ofs_b_lo_sh : ofs_b_lo;
    next_ofs_a_hi  = ofs_ld ? ofs_a_hi_sh : ofs_a_hi;
    next_ofs_b_hi  = ofs_ld ? ofs_b_hi_sh : ofs_b_hi;
  end

  // Reads show shadows: software sees what it wrote, with offset high bits 2:0 and control bits 7:1 read as zero
  always_comb begin
    next_rdata = iqc_pkg::RST_ZERO;
    if (rd_i) begin
      case (addr_i)
        iqc_pkg::ADDR_CORR_UPPER: next_rdata = upper_sh;
        iqc_pkg::ADDR_OFS_A_LO:   next_rdata = ofs_a_lo_sh;
        iqc_pkg::ADDR_OFS_B_LO:   next_rdata = ofs_b_lo_sh;
        iqc_pkg::ADDR_OFS_A_HI:   next_rdata = ofs_a_hi_sh;
        iqc_pkg::ADDR_OFS_B_HI:   next_rdata = ofs_b_hi_sh;
        iqc_pkg::ADDR_TEST_LO:    next_rdata = test_lo;
        iqc_pkg::ADDR_TEST_HI:    next_rdata = test_hi;
        iqc_pkg::ADDR_SYNC_SEL:   next_rdata = sel;
        iqc_pkg::ADDR_TEST_CTRL:  next_rdata = test_ctrl;
        default:                  next_rdata = iqc_pkg::RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      // Unity gain, zero phase at reset
      upper_sh    <= iqc_pkg::RST_CORR_UPPER;
      upper_act   <= iqc_pkg::RST_CORR_UPPER;
      ofs_a_lo_sh <= iqc_pkg::RST_ZERO;
      ofs_b_lo_sh <= iqc_pkg::RST_ZERO;
      ofs_a_hi_sh <= iqc_pkg::RST_ZERO;
      ofs_b_hi_sh <= iqc_pkg::RST_ZERO;
      ofs_a_lo    <= iqc_pkg::RST_ZERO;
      ofs_b_lo    <= iqc_pkg::RST_ZERO;
      ofs_a_hi    <= iqc_pkg::RST_ZERO;
      ofs_b_hi    <= iqc_pkg::RST_ZERO;
      test_lo     <= iqc_pkg::RST_ZERO;
      test_hi     <= iqc_pkg::RST_ZERO;
      test_ctrl   <= iqc_pkg::RST_ZERO;
      sel         <= iqc_pkg::iqc_sel_t'(iqc_pkg::RST_SYNC_SEL);
      rdata_o     <= iqc_pkg::RST_ZERO;
    end else begin
      upper_sh    <= next_upper_sh;
      upper_act   <= next_upper_act;
      ofs_a_lo_sh <= next_ofs_a_lo_sh;
      ofs_b_lo_sh <= next_ofs_b_lo_sh;
      ofs_a_hi_sh <= next_ofs_a_hi_sh;
      ofs_b_hi_sh <= next_ofs_b_hi_sh;
      ofs_a_lo    <= next_ofs_a_lo;
      ofs_b_lo    <= next_ofs_b_lo;
      ofs_a_hi    <= next_ofs_a_hi;
      ofs_b_hi    <= next_ofs_b_hi;
      test_lo     <= next_test_lo;
      test_hi     <= next_test_hi;
      test_ctrl   <= next_test_ctrl;
      sel         <= next_sel;
      rdata_o     <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  iqc_pkg::iqc_upper_t up;
  logic [OW-1:0]  ofs_a, ofs_b;
  logic [DW-1:0]  test_val;
  logic [DW-1:0]  next_conv_a, next_conv_b;
  logic [10:0]    next_gain_a, next_gain_b;
  logic [9:0]     next_phase;
  logic           next_nco_ph, next_nco_reg;

  always_comb begin
    up          = iqc_pkg::iqc_upper_t'(upper_act);
    ofs_a       = {ofs_a_hi[7:3], ofs_a_lo};
    ofs_b       = {ofs_b_hi[7:3], ofs_b_lo};
    test_val    = {test_hi, test_lo};
    // Gain upper bits, unsigned 1.10 format
    next_gain_a = {up.gain_a_hi, 8'h00};
    next_gain_b = {up.gain_b_hi, 8'h00};
    next_phase  = {up.phase_hi, 8'h00};
    if (test_ctrl[0]) begin
      next_conv_a = test_val;
      next_conv_b = test_val;
    end else begin
      next_conv_a = sat_add(sample_a_i, ofs_a);
      next_conv_b = sat_add(sample_b_i, ofs_b);
    end
    next_nco_ph  = pick_sync(sel.nco_phase, sync_i);
    next_nco_reg = pick_sync(sel.nco_reg, sync_i);
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      converter_a_o    <= '0;
      converter_b_o    <= '0;
      gain_a_hi_o      <= '0;
      gain_b_hi_o      <= '0;
      phase_hi_o       <= '0;
      nco_phase_sync_o <= 1'b0;
      nco_reg_sync_o   <= 1'b0;
    end else begin
      converter_a_o    <= next_conv_a;
      converter_b_o    <= next_conv_b;
      gain_a_hi_o      <= next_gain_a;
      gain_b_hi_o      <= next_gain_b;
      phase_hi_o       <= next_phase;
      nco_phase_sync_o <= next_nco_ph;
      nco_reg_sync_o   <= next_nco_reg;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_ofs_write;
    wr_i && addr_i == iqc_pkg::ADDR_OFS_A_LO;
  endsequence

  ofs_held_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !ofs_ld |=> ofs_a_lo == $past(ofs_a_lo)) else $error("offset changed without sync");
  ofs_load_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_ofs_write ##1 ofs_ld |=> ofs_a_lo == $past(wdata_i, 2)) else $error("offset not loaded");
  zero_sel_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    sel.corr == iqc_pkg::SYNC_ZERO |=> upper_act == $past(upper_act)) else $error("zero sync loaded");
  test_out_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    test_ctrl[0] |=> converter_a_o == $past(test_val) && converter_b_o == converter_a_o)
    else $error("test value not routed");
  ofs_add_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !test_ctrl[0] && sample_a_i == 16'h0000 |=> converter_a_o == {{3{$past(ofs_a[12])}}, $past(ofs_a)})
    else $error("offset add wrong");
  hi_mask_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wr_i && addr_i == iqc_pkg::ADDR_OFS_A_HI |=> ofs_a_hi_sh[2:0] == 3'h0) else $error("unused bits kept");
  rd_data_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    rd_i && addr_i == iqc_pkg::ADDR_TEST_HI |=> rdata_o == test_val[15:8]) else $error("test high readback");
  gain_out_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    1'b1 |=> gain_a_hi_o[10:8] == $past(upper_act[5:3]) && phase_hi_o[9:8] == $past(upper_act[7:6]))
    else $error("upper field position");
  rst_sel_a: assert property (@(posedge mclk_i)
    sys_rst_i |=> sel == iqc_pkg::iqc_sel_t'(iqc_pkg::RST_SYNC_SEL)) else $error("select reset value");

  // ----------------------------------------------------------------
  // Load, reset and field checks
  // ----------------------------------------------------------------
  sequence s_ctrl_ofs_sync;
    sel.offset == iqc_pkg::SYNC_CTRL && sync_i.ctrl_if_sync_bit;
  endsequence

  sequence s_fifo_corr_sync;
    sel.corr == iqc_pkg::SYNC_FIFO && sync_i.fifo_sync;
  endsequence

  sequence s_ofs_b_zero_in;
    !test_ctrl[0] && sample_b_i == 16'h0000;
  endsequence

  ofs_held_b_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !ofs_ld |=> ofs_b_lo == $past(ofs_b_lo) && ofs_a_hi == $past(ofs_a_hi) && ofs_b_hi == $past(ofs_b_hi))
    else $error("offset high or B changed without sync");

  ctrl_ofs_ld_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_ctrl_ofs_sync |=> ofs_b_lo == $past(ofs_b_lo_sh) && ofs_b_hi == $past(ofs_b_hi_sh))
    else $error("offset not loaded on control sync");

  corr_ld_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_fifo_corr_sync |=> upper_act == $past(upper_sh)) else $error("correction not loaded on sync");

  ofs_add_b_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_ofs_b_zero_in |=> converter_b_o == {{3{$past(ofs_b_hi[7])}}, $past(ofs_b_hi[7:3]), $past(ofs_b_lo)})
    else $error("offset B word wrong");

  hi_mask_b_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wr_i && addr_i == iqc_pkg::ADDR_OFS_B_HI |=> ofs_b_hi_sh[2:0] == 3'h0) else $error("unused B bits kept");

  gain_b_out_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    1'b1 |=> gain_b_hi_o[10:8] == $past(upper_act[2:0])) else $error("gain B field position");

  gain_low_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    1'b1 |=> gain_a_hi_o[7:0] == 8'h00 && gain_b_hi_o[7:0] == 8'h00 && phase_hi_o[7:0] == 8'h00)
    else $error("gain low bits not zero");

  nco_ph_sel_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    sel.nco_phase == iqc_pkg::SYNC_TXGATE |=> nco_phase_sync_o == $past(sync_i.transmit_gate))
    else $error("oscillator phase sync source");

  nco_reg_sel_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    sel.nco_reg == iqc_pkg::SYNC_FIFO |=> nco_reg_sync_o == $past(sync_i.fifo_sync))
    else $error("oscillator register sync source");

  test_sign_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    test_ctrl[0] |=> converter_b_o[15] == $past(test_hi[7])) else $error("test value sign bit");

  rst_ofs_a: assert property (@(posedge mclk_i)
    sys_rst_i |=> ofs_a_lo == iqc_pkg::RST_ZERO && ofs_a_hi == iqc_pkg::RST_ZERO
      && ofs_b_lo == iqc_pkg::RST_ZERO && ofs_b_hi == iqc_pkg::RST_ZERO) else $error("offset reset value");

  rst_upper_a: assert property (@(posedge mclk_i)
    sys_rst_i |=> upper_act == iqc_pkg::RST_CORR_UPPER && upper_sh == iqc_pkg::RST_CORR_UPPER)
    else $error("upper bits reset value");
endmodule
